//--- design/tlia_top.sv
// Top-level interrupt aggregator with APB registers
`timescale 1ns/1ps
module tlia_top import tlia_pkg::*; #(
    parameter int HMAC_N = HMAC_EVENTS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [HMAC_N-1:0] hostMacEvent,
    input wire logic energyPort1,
    input wire logic energyPort2,
    input wire logic wakeFrame,
    input wire logic timerWrap,
    output logic timerRun,
    output logic irq,
    input wire logic fabAck,
    input wire logic [31:0] fabRdata,
    output logic fabValid,
    output tlia_fab_req_s fabReq
);
    if (HMAC_N < 1 || HMAC_N > HMAC_EVENTS) begin : g_chk
        $error("HMAC_N must lie in 1..8");
    end

    logic [HMAC_N-1:0] hmacSt;
    logic timerSt;
    logic readySt;
    logic readySeen;
    logic softSt;
    logic [31:0] en;
    logic globalEn;
    logic [INTERVAL_W-1:0] interval;
    logic [2:0] pmFlags;
    logic [2:0] pmEn;
    logic [31:0] statusVal;
    logic [31:0] readVal;
    logic [31:0] cmdReg;
    logic [31:0] dataReg;
    logic [31:0] masked;
    logic setupHit;
    logic wr;
    logic mapped;
    logic wrStatus;
    logic wrEnable;
    logic irqWant;
    logic wakeWant;

    // APB: setup phase latches the answer, access phase commits it
    assign setupHit = psel & ~penable & ~pready;
    assign wr = psel & penable & pready & pwrite;
    assign wrStatus = wr && paddr == OFS_STATUS;
    assign wrEnable = wr && paddr == OFS_ENABLE;

    always_comb begin
        mapped = 1'b1;
        readVal = 32'h0000_0000;
        case (paddr)
            OFS_STATUS: readVal = statusVal;
            OFS_ENABLE: readVal = en;
            OFS_CONFIG: begin
                readVal[BIT_GLOBAL_EN] = globalEn;
                readVal[BIT_IRQ_LEVEL] = irq;
                readVal[INTERVAL_LSB +: INTERVAL_W] = interval;
            end
            OFS_PMCTRL: begin
                readVal[PM_FLAG_EN1] = pmFlags[0];
                readVal[PM_FLAG_EN2] = pmFlags[1];
                readVal[PM_FLAG_WOL] = pmFlags[2];
                readVal[PM_EN_EN1] = pmEn[0];
                readVal[PM_EN_EN2] = pmEn[1];
                readVal[PM_EN_WOL] = pmEn[2];
            end
            OFS_GTCFG: readVal[BIT_TIMER_RUN] = timerRun;
            OFS_FDATA: readVal = dataReg;
            OFS_FCMD: readVal = cmdReg;
            default: begin
                // Window reads return zero; reads go through data instead
                mapped = tlia_in_window(paddr);
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pready <= setupHit;
            if (setupHit) begin
                prdata <= pwrite ? 32'h0000_0000 : readVal;
                pslverr <= ~mapped;
            end else if (pready) begin
                pslverr <= 1'b0;
            end
        end
    end

    always_comb begin
        statusVal = STATUS_RST;
        statusVal[HMAC_N-1:0] = hmacSt;
        statusVal[BIT_WAKE_SUM] = |pmFlags;
        statusVal[BIT_TIMER] = timerSt;
        statusVal[BIT_READY] = readySt;
        statusVal[BIT_SOFT] = softSt;
    end

    // Sticky status: a set in the clear cycle wins
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hmacSt <= '0;
        end else if (clkEn) begin
            hmacSt <= hostMacEvent
                | (hmacSt & ~(wrStatus ? pwdata[HMAC_N-1:0] : '0));
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            timerSt <= 1'b0;
        end else if (clkEn) begin
            timerSt <= timerWrap
                | (timerSt & ~(wrStatus & pwdata[BIT_TIMER]));
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            readySt <= 1'b0;
            readySeen <= 1'b0;
        end else if (clkEn) begin
            readySeen <= 1'b1;
            // First enabled cycle after release marks the device usable
            readySt <= ~readySeen
                | (readySt & ~(wrStatus & pwdata[BIT_READY]));
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            softSt <= 1'b0;
        end else if (clkEn) begin
            softSt <= (wrEnable & pwdata[BIT_SOFT])
                | (softSt & ~(wrStatus & pwdata[BIT_SOFT]));
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            en <= ENABLE_RST;
        end else if (clkEn && wrEnable) begin
            en <= pwdata;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            globalEn <= 1'b0;
            interval <= INTERVAL_RST;
            timerRun <= 1'b0;
        end else if (clkEn && wr) begin
            if (paddr == OFS_CONFIG) begin
                globalEn <= pwdata[BIT_GLOBAL_EN];
                interval <= pwdata[INTERVAL_LSB +: INTERVAL_W];
            end
            if (paddr == OFS_GTCFG) begin
                timerRun <= pwdata[BIT_TIMER_RUN];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pmFlags <= 3'h0;
            pmEn <= 3'h0;
        end else if (clkEn) begin
            pmFlags[0] <= energyPort1
                | (pmFlags[0] & ~(wr && paddr == OFS_PMCTRL
                && pwdata[PM_FLAG_EN1]));
            pmFlags[1] <= energyPort2
                | (pmFlags[1] & ~(wr && paddr == OFS_PMCTRL
                && pwdata[PM_FLAG_EN2]));
            pmFlags[2] <= wakeFrame
                | (pmFlags[2] & ~(wr && paddr == OFS_PMCTRL
                && pwdata[PM_FLAG_WOL]));
            if (wr && paddr == OFS_PMCTRL) begin
                pmEn <= {pwdata[PM_EN_WOL], pwdata[PM_EN_EN2],
                    pwdata[PM_EN_EN1]};
            end
        end
    end

    // Wake summary takes its own path so the hold cannot delay it
    always_comb begin
        masked = statusVal & en;
        masked[BIT_WAKE_SUM] = 1'b0;
        masked[BIT_TIMER] = masked[BIT_TIMER] & timerRun;
    end

    assign irqWant = globalEn & (|masked);
    assign wakeWant = globalEn & en[BIT_WAKE_SUM]
        & (|(pmFlags & pmEn));

    tlia_pacer i_tlia_pacer (
        .ref_clk(ref_clk),
        .reset(reset),
        .clkEn(clkEn),
        .want(irqWant),
        .wakeWant(wakeWant),
        .interval(interval),
        .irq(irq)
    );

    tlia_fabric i_tlia_fabric (
        .ref_clk(ref_clk),
        .reset(reset),
        .clkEn(clkEn),
        .wrCmd(wr && paddr == OFS_FCMD),
        .wrData(wr && paddr == OFS_FDATA),
        .wrWin(wr && tlia_in_window(paddr)),
        .winIdx(paddr[7:2]),
        .wdata(pwdata),
        .fabAck(fabAck),
        .fabRdata(fabRdata),
        .cmdReg(cmdReg),
        .dataReg(dataReg),
        .fabValid(fabValid),
        .fabReq(fabReq)
    );

    property p_timer_set;
        @(posedge ref_clk) disable iff (reset)
        (clkEn && timerWrap) |=> statusVal[BIT_TIMER];
    endproperty
    a_timer_set: assert property (p_timer_set)
        else $error("timer wrap not flagged");

    property p_timer_keep;
        @(posedge ref_clk) disable iff (reset)
        (timerSt && !(wrStatus && pwdata[BIT_TIMER])) |=> timerSt;
    endproperty
    a_timer_keep: assert property (p_timer_keep)
        else $error("timer flag lost without a written one");

    property p_ready_clear;
        @(posedge ref_clk) disable iff (reset)
        (clkEn && readySeen && wrStatus && pwdata[BIT_READY]) |=> !readySt;
    endproperty
    a_ready_clear: assert property (p_ready_clear)
        else $error("ready flag not cleared");

    property p_soft_set;
        @(posedge ref_clk) disable iff (reset)
        (clkEn && wrEnable && pwdata[BIT_SOFT]) |=> softSt ##1 en[BIT_SOFT];
    endproperty
    a_soft_set: assert property (p_soft_set)
        else $error("software event not raised");

    property p_wake_sum;
        @(posedge ref_clk) disable iff (reset)
        (clkEn && (energyPort1 || energyPort2 || wakeFrame))
            |=> statusVal[BIT_WAKE_SUM];
    endproperty
    a_wake_sum: assert property (p_wake_sum)
        else $error("wake summary disagrees with flags");

    property p_global_off;
        @(posedge ref_clk) disable iff (reset)
        (clkEn && !globalEn) |=> !irq;
    endproperty
    a_global_off: assert property (p_global_off)
        else $error("pin raised without global enable");

    property p_timer_gate;
        @(posedge ref_clk) disable iff (reset)
        (clkEn && !timerRun && !wakeWant && (statusVal & en
            & ~(32'h0000_0001 << BIT_WAKE_SUM)
            & ~(32'h0000_0001 << BIT_TIMER)) == 32'h0000_0000)
            |=> !irq;
    endproperty
    a_timer_gate: assert property (p_timer_gate)
        else $error("stopped timer reached the pin");

    property p_pin_up;
        @(posedge ref_clk) disable iff (reset)
        $rose(irq) |-> $past(irqWant) || $past(wakeWant);
    endproperty
    a_pin_up: assert property (p_pin_up)
        else $error("pin rose with no enabled source");
endmodule : tlia_top

//--- design/tlia_pkg.sv
// Shared constants and types of the top-level interrupt aggregator
package tlia_pkg;
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_ENABLE = 12'h004;
    localparam logic [11:0] OFS_CONFIG = 12'h008;
    localparam logic [11:0] OFS_PMCTRL = 12'h00C;
    localparam logic [11:0] OFS_GTCFG = 12'h010;
    localparam logic [11:0] OFS_FDATA = 12'h014;
    localparam logic [11:0] OFS_FCMD = 12'h018;
    localparam logic [11:0] OFS_WINDOW = 12'h100;
    localparam int WINDOW_WORDS = 64;

    localparam int HMAC_EVENTS = 8;
    localparam int BIT_GLOBAL_EN = 8;
    localparam int BIT_IRQ_LEVEL = 12;
    localparam int BIT_WAKE_SUM = 17;
    localparam int BIT_TIMER = 19;
    localparam int BIT_READY = 30;
    localparam int BIT_SOFT = 31;
    localparam int BIT_TIMER_RUN = 29;
    localparam int INTERVAL_LSB = 24;
    localparam int INTERVAL_W = 8;

    localparam int PM_FLAG_EN1 = 0;
    localparam int PM_FLAG_EN2 = 1;
    localparam int PM_FLAG_WOL = 2;
    localparam int PM_EN_WOL = 9;
    localparam int PM_EN_EN1 = 14;
    localparam int PM_EN_EN2 = 15;

    localparam int CMD_BUSY = 31;
    localparam int CMD_RNW = 30;
    localparam int CMD_BE_LSB = 16;

    localparam logic [31:0] STATUS_RST = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
    localparam logic [7:0] INTERVAL_RST = 8'h00;
    localparam logic [3:0] BE_ALL = 4'hF;

    localparam int CLK_PERIOD_NS = 10;
    localparam int INTERVAL_UNIT_NS = 10000;
    localparam int UNIT_CYCLES = INTERVAL_UNIT_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } tlia_fab_req_s;

    typedef enum logic {FAB_IDLE, FAB_WAIT} tlia_fab_e;

    function automatic logic tlia_in_window(input logic [11:0] a);
        return a >= OFS_WINDOW && a < OFS_WINDOW + 12'(4 * WINDOW_WORDS);
    endfunction : tlia_in_window
endpackage : tlia_pkg

//--- design/tlia_pacer.sv
// Request pin driver with minimum inactive interval; wake requests are not held off by it
`timescale 1ns/1ps
module tlia_pacer import tlia_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic want,
    input wire logic wakeWant,
    input wire logic [INTERVAL_W-1:0] interval,
    output logic irq
);
    logic [INTERVAL_W-1:0] holdUnits;
    logic [11:0] pre;
    logic next_irq;

    // Wake requests bypass the hold window, but the pin falling after a wake still starts it
    assign next_irq = wakeWant | (want & (holdUnits == '0));

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else if (clkEn) begin
            irq <= next_irq;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            holdUnits <= '0;
            pre <= '0;
        end else if (clkEn) begin
            if (irq && !next_irq) begin
                holdUnits <= interval;
                pre <= 12'(UNIT_CYCLES - 1);
            end else if (holdUnits != '0) begin
                if (pre == '0) begin
                    holdUnits <= holdUnits - 1'b1;
                    pre <= 12'(UNIT_CYCLES - 1);
                end else begin
                    pre <= pre - 1'b1;
                end
            end
        end
    end

    property p_hold_low;
        @(posedge ref_clk) disable iff (reset)
        (clkEn && irq && !next_irq && interval != '0) |=>
            (holdUnits == $past(interval))
            ##1 (!irq || $past(wakeWant));
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("inactive hold not started");
endmodule : tlia_pacer

//--- design/tlia_fabric.sv
// Indirect path to the switch-fabric registers
`timescale 1ns/1ps
module tlia_fabric import tlia_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic wrCmd,
    input wire logic wrData,
    input wire logic wrWin,
    input wire logic [5:0] winIdx,
    input wire logic [31:0] wdata,
    input wire logic fabAck,
    input wire logic [31:0] fabRdata,
    output logic [31:0] cmdReg,
    output logic [31:0] dataReg,
    output logic fabValid,
    output tlia_fab_req_s fabReq
);
    tlia_fab_e state;
    logic start;
    logic [31:0] next_cmd;

    // Window writes map directly onto fabric writes; busy command writes start the rest
    always_comb begin
        start = 1'b0;
        next_cmd = cmdReg;
        if (state == FAB_IDLE && wrWin) begin
            start = 1'b1;
            next_cmd = '0;
            next_cmd[CMD_BUSY] = 1'b1;
            next_cmd[CMD_BE_LSB +: 4] = BE_ALL;
            next_cmd[15:0] = {8'h00, winIdx, 2'b00};
        end else if (state == FAB_IDLE && wrCmd && wdata[CMD_BUSY]) begin
            start = 1'b1;
            next_cmd = wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= FAB_IDLE;
            cmdReg <= 32'h0000_0000;
            fabValid <= 1'b0;
            fabReq <= '0;
        end else if (clkEn) begin
            case (state)
                FAB_IDLE: begin
                    if (start) begin
                        state <= FAB_WAIT;
                        cmdReg <= next_cmd;
                        fabValid <= 1'b1;
                        fabReq.write <= !next_cmd[CMD_RNW];
                        fabReq.addr <= next_cmd[15:0];
                        fabReq.be <= next_cmd[CMD_BE_LSB +: 4];
                        fabReq.wdata <= wrWin ? wdata : dataReg;
                    end else if (wrCmd) begin
                        cmdReg <= wdata;
                    end
                end
                FAB_WAIT: begin
                    if (fabAck) begin
                        state <= FAB_IDLE;
                        fabValid <= 1'b0;
                        cmdReg[CMD_BUSY] <= 1'b0;
                    end
                end
                default: state <= FAB_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dataReg <= 32'h0000_0000;
        end else if (clkEn) begin
            if (state == FAB_WAIT && fabAck && !fabReq.write) begin
                dataReg <= fabRdata;
            end else if (state == FAB_IDLE && (wrData || wrWin)) begin
                dataReg <= wdata;
            end
        end
    end

    property p_window_start;
        @(posedge ref_clk) disable iff (reset)
        (clkEn && wrWin && state == FAB_IDLE) |=>
            fabValid && fabReq.write && fabReq.be == BE_ALL;
    endproperty
    a_window_start: assert property (p_window_start)
        else $error("window write did not start a fabric write");
endmodule : tlia_fabric

//--- verification/tlia_fab_model.sv
// Behavioural switch-fabric responder for the indirect access path
`timescale 1ns/1ps
module tlia_fab_model import tlia_pkg::*; #(
    parameter int LAT = 3
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic fabValid,
    input wire tlia_fab_req_s fabReq,
    output logic fabAck,
    output logic [31:0] fabRdata
);
    int cnt;

    // Reply echoes the address so a read can be traced to its request
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt <= 0;
            fabAck <= 1'b0;
            fabRdata <= 32'h0000_0000;
        end else begin
            fabAck <= 1'b0;
            // Stale read data toggles so it never passes for a reply
            fabRdata <= ~fabRdata;
            if (fabValid && !fabAck) begin
                cnt <= cnt + 1;
                if (cnt == LAT) begin
                    cnt <= 0;
                    fabAck <= 1'b1;
                    fabRdata <= {16'hA5C3, fabReq.addr};
                end
            end
        end
    end
endmodule : tlia_fab_model

//--- verification/tlia_top_tb.sv
// Self-checking bench for the top-level interrupt aggregator
`timescale 1ns/1ps
module tlia_top_tb import tlia_pkg::*; ;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pready, pslverr, timerRun, irq, fabAck, fabValid;
    logic [31:0] prdata, fabRdata, rd;
    logic [7:0] hostMacEvent = 8'h00;
    logic [2:0] wk = 3'h0;
    logic timerWrap = 1'b0;
    logic clkEn = 1'b1;
    logic se;
    tlia_fab_req_s fabReq;
    int failCount = 0;
    int totalChecks = 0;

    always #5 ref_clk = ~ref_clk;

    tlia_top i_tlia_top (
        .ref_clk(ref_clk), .reset(reset), .clkEn(clkEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .hostMacEvent(hostMacEvent),
        .energyPort1(wk[0]), .energyPort2(wk[1]), .wakeFrame(wk[2]),
        .timerWrap(timerWrap), .timerRun(timerRun), .irq(irq),
        .fabAck(fabAck), .fabRdata(fabRdata), .fabValid(fabValid),
        .fabReq(fabReq)
    );

    tlia_fab_model i_tlia_fab_model (
        .ref_clk(ref_clk), .reset(reset), .fabValid(fabValid),
        .fabReq(fabReq), .fabAck(fabAck), .fabRdata(fabRdata)
    );

    task automatic endSim();
        if (failCount == 0 && totalChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : endSim

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        totalChecks++;
        if (g !== e) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic hang(input string n);
        failCount++;
        $display("CHECK FAILED %s expected answer seen timeout", n);
        endSim();
    endtask : hang

    // Setup, then access held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Read at the access edge, before the flops take new values
        do begin
            @(posedge ref_clk);
            n++;
            if (n > 20) hang("pready");
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input string n, input logic [11:0] a,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, e, rd);
    endtask : rdc

    task automatic waitIrq(input logic e, input int b);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
            if (n > b) hang("irq");
        end while (irq !== e);
        chk("irq", 32'(e), 32'(irq));
        @(posedge ref_clk);
    endtask : waitIrq

    task automatic holdIrq(input logic e, input int b);
        logic ok;
        ok = 1'b1;
        repeat (b) begin
            @(negedge ref_clk);
            if (irq !== e) ok = 1'b0;
        end
        chk("irq steady", 32'h0000_0001, 32'(ok));
        @(posedge ref_clk);
    endtask : holdIrq

    task automatic pulse(input logic [7:0] h, input logic [2:0] w,
                         input logic t);
        hostMacEvent <= h;
        wk <= w;
        timerWrap <= t;
        @(posedge ref_clk);
        hostMacEvent <= 8'h00;
        wk <= 3'h0;
        timerWrap <= 1'b0;
        @(posedge ref_clk);
    endtask : pulse

    task automatic clr();
        wr(OFS_ENABLE, 32'h0000_0000);
        wr(OFS_CONFIG, 32'h0000_0000);
        wr(OFS_GTCFG, 32'h0000_0000);
        wr(OFS_STATUS, 32'hFFFF_FFFF);
        wr(OFS_PMCTRL, 32'h0000_0007);
    endtask : clr

    task automatic tReady();
        rdc("status", OFS_STATUS, 32'h4000_0000);
        rdc("enable", OFS_ENABLE, ENABLE_RST);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, 32'(se));
        chk("unmapped data", 32'h0000_0000, rd);
        wr(OFS_ENABLE, 32'h4000_0000);
        holdIrq(1'b0, 4);
        wr(OFS_CONFIG, 32'h0000_0100);
        waitIrq(1'b1, 5);
        wr(OFS_STATUS, 32'h4000_0000);
        waitIrq(1'b0, 5);
        rdc("status", OFS_STATUS, 32'h0000_0000);
        clr();
    endtask : tReady

    task automatic tHmac();
        pulse(8'h08, 3'h0, 1'b0);
        rdc("status", OFS_STATUS, 32'h0000_0008);
        wr(OFS_ENABLE, 32'h0000_0008);
        holdIrq(1'b0, 4);
        wr(OFS_CONFIG, 32'h0000_0100);
        waitIrq(1'b1, 5);
        wr(OFS_CONFIG, 32'h0000_0000);
        waitIrq(1'b0, 5);
        clr();
    endtask : tHmac

    task automatic tTimer();
        // A wrap while the enable is low must be missed entirely
        clkEn <= 1'b0;
        pulse(8'h00, 3'h0, 1'b1);
        clkEn <= 1'b1;
        rdc("frozen", OFS_STATUS, 32'h0000_0000);
        pulse(8'h00, 3'h0, 1'b1);
        rdc("status", OFS_STATUS, 32'h0008_0000);
        wr(OFS_STATUS, 32'h0000_0000);
        rdc("status", OFS_STATUS, 32'h0008_0000);
        wr(OFS_ENABLE, 32'h0008_0000);
        wr(OFS_CONFIG, 32'h0000_0100);
        holdIrq(1'b0, 4);
        wr(OFS_GTCFG, 32'h2000_0000);
        chk("timerRun", 32'h0000_0001, 32'(timerRun));
        waitIrq(1'b1, 5);
        wr(OFS_STATUS, 32'h0008_0000);
        waitIrq(1'b0, 5);
        clr();
    endtask : tTimer

    task automatic tWake();
        int en[3] = '{PM_EN_EN1, PM_EN_EN2, PM_EN_WOL};
        wr(OFS_ENABLE, 32'h0002_0000);
        wr(OFS_CONFIG, 32'h0000_0100);
        for (int i = 0; i < 3; i++) begin
            pulse(8'h00, 3'(1 << i), 1'b0);
            rdc("pm flags", OFS_PMCTRL, 32'(1) << i);
            rdc("summary", OFS_STATUS, 32'h0002_0000);
            holdIrq(1'b0, 3);
            wr(OFS_PMCTRL, 32'(1) << en[i]);
            waitIrq(1'b1, 5);
            wr(OFS_PMCTRL, 32'(1) << i);
            waitIrq(1'b0, 5);
            rdc("summary", OFS_STATUS, 32'h0000_0000);
        end
        clr();
    endtask : tWake

    // One interval unit keeps the pin low for a thousand cycles
    task automatic tHold();
        wr(OFS_CONFIG, 32'h0100_0100);
        wr(OFS_ENABLE, 32'h8000_0000);
        rdc("status", OFS_STATUS, 32'h8000_0000);
        waitIrq(1'b1, 5);
        wr(OFS_STATUS, 32'h8000_0000);
        waitIrq(1'b0, 5);
        wr(OFS_ENABLE, 32'h8000_0000);
        holdIrq(1'b0, 700);
        waitIrq(1'b1, UNIT_CYCLES);
        wr(OFS_STATUS, 32'h8000_0000);
        waitIrq(1'b0, 5);
        wr(OFS_ENABLE, 32'h0002_0000);
        wr(OFS_PMCTRL, 32'(1) << PM_EN_WOL);
        pulse(8'h00, 3'h4, 1'b0);
        waitIrq(1'b1, 5);
        clr();
    endtask : tHold

    task automatic fabWait();
        int n;
        n = 0;
        do begin
            apb(1'b0, OFS_FCMD, 32'h0000_0000);
            n++;
            if (n > 10) hang("busy");
        end while (rd[CMD_BUSY] !== 1'b0);
    endtask : fabWait

    task automatic tFabric();
        wr(OFS_WINDOW + 12'h008, 32'h1234_5678);
        @(negedge ref_clk);
        chk("fabValid", 32'h0000_0001, 32'(fabValid));
        chk("req write", 32'h0000_0001, 32'(fabReq.write));
        chk("req addr", 32'h0000_0008, 32'(fabReq.addr));
        chk("req be", 32'(BE_ALL), 32'(fabReq.be));
        chk("req data", 32'h1234_5678, fabReq.wdata);
        @(posedge ref_clk);
        fabWait();
        wr(OFS_FCMD, 32'hC00F_0123);
        @(negedge ref_clk);
        chk("req write", 32'h0000_0000, 32'(fabReq.write));
        chk("req addr", 32'h0000_0123, 32'(fabReq.addr));
        @(posedge ref_clk);
        fabWait();
        rdc("fabric data", OFS_FDATA, 32'hA5C3_0123);
    endtask : tFabric

    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        tReady();
        tHmac();
        tTimer();
        tWake();
        tHold();
        tFabric();
        endSim();
    end
endmodule : tlia_top_tb
